// *** hw/tac_dev.sv ***
// Functional notes
// [RULE_01] t0 loads coarse counter with start value
// [RULE_02] natural wrap: latency is offset difference mod 4096
// [RULE_03] trigger matches measurement at latency distance
// [RULE_04] counters wrap at programmable limit
// [RULE_05] configurer adds excluded region when between offsets
// [RULE_06] zero coarse: tag offset = limit-latency+1
// [RULE_07] reject counter drops measurements past limit
// [RULE_08] configurer sets reject limit latency plus two
// [RULE_09] reject offset accounts excluded region too
// [RULE_10] trim loads tap outputs, shifting bin boundary
// [RULE_11] trim zero lengthens bin 27, shortens 28
// [RULE_12] two coarse counters on opposite phases, selected; here both count on the rising edge, b one cycle behind a
// [RULE_13] very high resolution: trims ramp 0..7 by fours
// [RULE_14] low resolution: trims may stay zero
// [RULE_15] reported time includes coarse offset, channel adjust
// [RULE_16] t0 resets all four counters together
// [RULE_17] trigger stores current tag count entry
// [RULE_18] counters increment, return to zero past limit
// [RULE_19] t0 wins over counting on same edge
`timescale 1ns/100ps
module tac_dev
    import tac_pkg::*;
(
    input  wire logic                      CLK_SYS,
    input  wire logic                      RST_B,
    tac_if.dev                             LINK,
    input  wire logic                      HIT,
    input  wire logic [TAP_W-1:0]          HIT_TAP,
    input  wire logic [1:0]                HIT_CHAN,
    output logic                           TRIG_VALID,
    output logic [CNT_W-1:0]               TRIG_TAG,
    output logic                           MEAS_VALID,
    output logic [TIME_W-1:0]              MEAS_TIME,
    output logic                           MEAS_REJECT,
    output logic [TIME_W-1:0]              REJECT_TIME,
    output logic [TAP_N*TRIM_W-1:0]        TAP_LOAD,
    output logic [TAP_N*TAP_W-1:0]         TAP_BIN
);
    logic [CNT_W-1:0]     coarse_a_r;
    logic [CNT_W-1:0]     coarse_b_r;
    logic [CNT_W-1:0]     tag_r;
    logic [CNT_W-1:0]     rej_r;
    logic                 hit_s1_r;
    logic                 hit_s2_r;
    logic                 hit_s3_r;
    logic [TAP_W-1:0]     tap_s1_r;
    logic [TAP_W-1:0]     tap_s2_r;
    logic [1:0]           chan_s1_r;
    logic [1:0]           chan_s2_r;
    logic                 hit_evt;
    logic [TAP_W-1:0]     fine_bin;
    logic [CNT_W-1:0]     coarse_sel;
    logic [ADJ_W-1:0]     adj_sel;
    logic [TIME_W-1:0]    raw_time;
    logic [TIME_W-1:0]    hit_time;
    logic                 pend_r;
    logic [TIME_W-1:0]    pend_time_r;
    logic                 match_now;
    logic                 reject_now;

    function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] v,
                                                  input logic [CNT_W-1:0] lim);
        logic [CNT_W-1:0] r;
        r = (v >= lim) ? CNT_ZERO : v + CNT_ONE;
        return r;
    endfunction : wrap_inc

    // phase-a coarse counter
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            coarse_a_r <= CNT_ZERO;
        end else if (LINK.t0_pulse) begin
            coarse_a_r <= LINK.coarse_off; // [RULE_01] [RULE_16] [RULE_19]
        end else begin
            coarse_a_r <= wrap_inc(coarse_a_r, LINK.rollover); // [RULE_04] [RULE_18]
        end
    end

    // phase-b coarse counter trails phase a by one CLK_SYS cycle
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            coarse_b_r <= CNT_ZERO;
        end else if (LINK.t0_pulse) begin
            coarse_b_r <= LINK.coarse_off; // [RULE_16] [RULE_19]
        end else begin
            coarse_b_r <= coarse_a_r; // [RULE_12]
        end
    end

    // trigger time tag counter
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            tag_r <= CNT_ZERO;
        end else if (LINK.t0_pulse) begin
            tag_r <= LINK.tag_off; // [RULE_16] [RULE_19]
        end else begin
            tag_r <= wrap_inc(tag_r, LINK.rollover); // [RULE_04] [RULE_18]
        end
    end

    // reject counter
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rej_r <= CNT_ZERO;
        end else if (LINK.t0_pulse) begin
            rej_r <= LINK.rej_off; // [RULE_16] [RULE_19]
        end else begin
            rej_r <= wrap_inc(rej_r, LINK.rollover); // [RULE_04] [RULE_18]
        end
    end

    assign LINK.stat_coarse = coarse_a_r;
    assign LINK.stat_tag    = tag_r;

    // hit pin synchronisers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            hit_s1_r  <= 1'b0;
            hit_s2_r  <= 1'b0;
            hit_s3_r  <= 1'b0;
            tap_s1_r  <= '0;
            tap_s2_r  <= '0;
            chan_s1_r <= '0;
            chan_s2_r <= '0;
        end else begin
            hit_s1_r  <= HIT;
            hit_s2_r  <= hit_s1_r;
            hit_s3_r  <= hit_s2_r;
            tap_s1_r  <= HIT_TAP;
            tap_s2_r  <= tap_s1_r;
            chan_s1_r <= HIT_CHAN;
            chan_s2_r <= chan_s1_r;
        end
    end

    assign hit_evt = hit_s2_r && !hit_s3_r;

    // tap to encoded bin: tap k closes bin k+27
    assign fine_bin = tap_s2_r + BIN_SHIFT; // [RULE_11]

    // late taps belong to phase a, early taps to the trailing phase b
    assign coarse_sel = tap_s2_r[TAP_W-1] ? coarse_a_r : coarse_b_r; // [RULE_12]

    assign adj_sel  = LINK.chan_adj[chan_s2_r*ADJ_W +: ADJ_W];
    assign raw_time = {coarse_sel, fine_bin};
    assign hit_time = raw_time + {{(TIME_W-ADJ_W){1'b0}}, adj_sel}; // [RULE_15]

    // matching against the trigger tag; equal coarse means latency distance
    assign match_now  = pend_r && LINK.trig_pulse
                        && (pend_time_r[TIME_W-1:TAP_W] == tag_r); // [RULE_02] [RULE_03]
    assign reject_now = pend_r && !match_now
                        && (pend_time_r[TIME_W-1:TAP_W] == rej_r); // [RULE_07]

    // one pending measurement awaiting trigger or reject
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            pend_r      <= 1'b0;
            pend_time_r <= '0;
        end else if (hit_evt) begin
            pend_r      <= 1'b1;
            pend_time_r <= hit_time;
        end else if (match_now || reject_now) begin
            pend_r      <= 1'b0; // [RULE_07]
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            MEAS_VALID <= 1'b0;
            MEAS_TIME  <= '0;
        end else begin
            MEAS_VALID <= match_now;
            if (match_now) begin
                MEAS_TIME <= pend_time_r; // [RULE_15]
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            MEAS_REJECT <= 1'b0;
            REJECT_TIME <= '0;
        end else begin
            MEAS_REJECT <= reject_now;
            if (reject_now) begin
                REJECT_TIME <= pend_time_r;
            end
        end
    end

    // trigger entry with the current tag count
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            TRIG_VALID <= 1'b0;
            TRIG_TAG   <= CNT_ZERO;
        end else begin
            TRIG_VALID <= LINK.trig_pulse; // [RULE_17]
            if (LINK.trig_pulse) begin
                TRIG_TAG <= tag_r; // [RULE_17]
            end
        end
    end

    // per-tap load on the delay-chain outputs and its bin label
    genvar gi;
    generate
        for (gi = 0; gi < TAP_N; gi++) begin : g_tap
            localparam logic [TAP_W-1:0] TAP_IDX = TAP_W'(gi);
            always_ff @(posedge CLK_SYS or negedge RST_B) begin
                if (!RST_B) begin
                    TAP_LOAD[gi*TRIM_W +: TRIM_W] <= '0;
                    TAP_BIN[gi*TAP_W +: TAP_W]    <= '0;
                end else begin
                    TAP_LOAD[gi*TRIM_W +: TRIM_W] <=
                        LINK.tap_trim[gi*TRIM_W +: TRIM_W]; // [RULE_10]
                    TAP_BIN[gi*TAP_W +: TAP_W]    <= TAP_IDX + BIN_SHIFT; // [RULE_11]
                end
            end
        end
    endgenerate
endmodule : tac_dev

// *** hw/tac_pkg.sv ***
package tac_pkg;
    localparam int CNT_W             = 12;
    localparam int TAP_N             = 32;
    localparam int TAP_W             = 5;
    localparam int TRIM_W            = 3;
    localparam int CH_N              = 4;
    localparam int ADJ_W             = 8;
    localparam int TIME_W            = CNT_W + TAP_W;

    localparam logic [CNT_W-1:0]  CNT_NATURAL_MAX = 12'hFFF;
    localparam logic [CNT_W-1:0]  CNT_ONE         = 12'h001;
    localparam logic [CNT_W-1:0]  CNT_ZERO        = 12'h000;
    localparam logic [CNT_W-1:0]  REJECT_MARGIN   = 12'h002;
    localparam logic [TAP_W-1:0]  BIN_SHIFT       = 5'h1B;
    localparam int                TRIM_GROUP_LOG2 = 2;

    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_COARSE   = 8'h04;
    localparam logic [7:0] OFS_LATENCY  = 8'h08;
    localparam logic [7:0] OFS_ROLLOVER = 8'h0C;
    localparam logic [7:0] OFS_CHAN_ADJ = 8'h10;
    localparam logic [7:0] OFS_TRIM     = 8'h14;
    localparam logic [7:0] OFS_OFFSETS  = 8'h18;
    localparam logic [7:0] OFS_STATUS   = 8'h1C;

    localparam int CTRL_T0_BIT   = 0;
    localparam int CTRL_TRIG_BIT = 1;

    localparam logic [CNT_W-1:0] RST_COARSE   = 12'h000;
    localparam logic [CNT_W-1:0] RST_LATENCY  = 12'h100;
    localparam logic [CNT_W-1:0] RST_ROLLOVER = 12'hFFF;
    localparam logic [31:0]      RST_CHAN_ADJ = 32'h0000_0000;

    typedef enum logic [1:0] {
        TAC_TRIM_ZERO,
        TAC_TRIM_RAMP
    } tac_trim_type;
endpackage : tac_pkg

// *** hw/tac_if.sv ***
`timescale 1ns/100ps
interface tac_if;
    import tac_pkg::*;
    logic                     t0_pulse;
    logic                     trig_pulse;
    logic [CNT_W-1:0]         coarse_off;
    logic [CNT_W-1:0]         tag_off;
    logic [CNT_W-1:0]         rej_off;
    logic [CNT_W-1:0]         rollover;
    logic [CH_N*ADJ_W-1:0]    chan_adj;
    logic [TAP_N*TRIM_W-1:0]  tap_trim;
    logic [CNT_W-1:0]         stat_coarse;
    logic [CNT_W-1:0]         stat_tag;

    modport dev (
        input  t0_pulse, trig_pulse, coarse_off, tag_off, rej_off, rollover, chan_adj,
        input  tap_trim,
        output stat_coarse, stat_tag
    );
    modport cfg (
        output t0_pulse, trig_pulse, coarse_off, tag_off, rej_off, rollover, chan_adj,
        output tap_trim,
        input  stat_coarse, stat_tag
    );
endinterface : tac_if

// *** hw/tac_cfg.sv ***
`timescale 1ns/100ps
module tac_cfg
    import tac_pkg::*;
(
    input  wire logic          CLK_SYS,
    input  wire logic          RST_B,
    tac_if.cfg                 LINK,
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [7:0]    PADDR,
    input  wire logic [31:0]   PWDATA,
    output logic [31:0]        PRDATA,
    output logic               PREADY,
    output logic               PSLVERR
);
    logic [CNT_W-1:0]   coarse_r;
    logic [CNT_W-1:0]   latency_r;
    logic [CNT_W-1:0]   rollover_r;
    logic [31:0]        chan_adj_r;
    tac_trim_type       trim_mode_r;
    logic               t0_r;
    logic               trig_r;
    logic               wr_en;
    logic               rd_en;
    logic               mapped;
    logic [CNT_W-1:0]   tag_nxt;
    logic [CNT_W-1:0]   rej_nxt;
    logic [31:0]        rd_word;

    // offset below coarse, skipping the excluded region when crossed
    function automatic logic [CNT_W-1:0] back_off(input logic [CNT_W-1:0] c,
                                                  input logic [CNT_W-1:0] d,
                                                  input logic [CNT_W-1:0] lim);
        logic [CNT_W:0] t;
        t = {1'b0, c} - {1'b0, d};
        if (c < d) begin
            t = t + {1'b0, lim} + {1'b0, CNT_ONE}; // [RULE_05] [RULE_06]
        end
        return t[CNT_W-1:0];
    endfunction : back_off

    assign tag_nxt = back_off(coarse_r, latency_r, rollover_r); // [RULE_05] [RULE_06]
    // reject fires one count after the limit, so its offset sits one further back
    assign rej_nxt = back_off(coarse_r, latency_r + REJECT_MARGIN + CNT_ONE,
                              rollover_r); // [RULE_08] [RULE_09]

    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && !PWRITE;
    assign mapped  = (PADDR == OFS_CTRL) || (PADDR == OFS_COARSE) || (PADDR == OFS_LATENCY)
                     || (PADDR == OFS_ROLLOVER) || (PADDR == OFS_CHAN_ADJ)
                     || (PADDR == OFS_TRIM) || (PADDR == OFS_OFFSETS) || (PADDR == OFS_STATUS);
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            coarse_r    <= RST_COARSE;
            latency_r   <= RST_LATENCY;
            rollover_r  <= RST_ROLLOVER;
            chan_adj_r  <= RST_CHAN_ADJ;
            trim_mode_r <= TAC_TRIM_ZERO;
        end else if (wr_en) begin
            case (PADDR)
                OFS_COARSE:   coarse_r    <= PWDATA[CNT_W-1:0];
                OFS_LATENCY:  latency_r   <= PWDATA[CNT_W-1:0];
                OFS_ROLLOVER: rollover_r  <= PWDATA[CNT_W-1:0];
                OFS_CHAN_ADJ: chan_adj_r  <= PWDATA;
                OFS_TRIM:     trim_mode_r <= PWDATA[0] ? TAC_TRIM_RAMP : TAC_TRIM_ZERO;
                default:      coarse_r    <= coarse_r;
            endcase
        end
    end

    // command pulses, one cycle each
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            t0_r   <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            t0_r   <= wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_T0_BIT];
            trig_r <= wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_TRIG_BIT];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (PADDR)
            OFS_COARSE:   rd_word = {20'h0_0000, coarse_r};
            OFS_LATENCY:  rd_word = {20'h0_0000, latency_r};
            OFS_ROLLOVER: rd_word = {20'h0_0000, rollover_r};
            OFS_CHAN_ADJ: rd_word = chan_adj_r;
            OFS_TRIM:     rd_word = {31'h0000_0000, trim_mode_r == TAC_TRIM_RAMP};
            OFS_OFFSETS:  rd_word = {4'h0, rej_nxt, 4'h0, tag_nxt};
            OFS_STATUS:   rd_word = {4'h0, LINK.stat_tag, 4'h0, LINK.stat_coarse};
            default:      rd_word = 32'h0000_0000;
        endcase
    end

    // read data captured in the setup phase, held through the access phase
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en && !PENABLE) begin
            PRDATA <= rd_word;
        end
    end

    assign LINK.t0_pulse   = t0_r;
    assign LINK.trig_pulse = trig_r;
    assign LINK.coarse_off = coarse_r;
    assign LINK.tag_off    = tag_nxt;
    assign LINK.rej_off    = rej_nxt;
    assign LINK.rollover   = rollover_r;
    assign LINK.chan_adj   = chan_adj_r[CH_N*ADJ_W-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < TAP_N; gi++) begin : g_trim
            localparam logic [TRIM_W-1:0] RAMP = TRIM_W'(gi >> TRIM_GROUP_LOG2);
            assign LINK.tap_trim[gi*TRIM_W +: TRIM_W] =
                (trim_mode_r == TAC_TRIM_RAMP) ? RAMP : '0; // [RULE_13] [RULE_14]
        end
    endgenerate
endmodule : tac_cfg

// *** verification/tac_properties.sv ***
`timescale 1ns/100ps
module tac_properties
    import tac_pkg::*;
(
    input wire logic             CLK_SYS,
    input wire logic             RST_B,
    input wire logic             t0_pulse,
    input wire logic             trig_pulse,
    input wire logic [CNT_W-1:0] coarse_off,
    input wire logic [CNT_W-1:0] tag_off,
    input wire logic [CNT_W-1:0] rollover,
    input wire logic [CNT_W-1:0] stat_coarse,
    input wire logic [CNT_W-1:0] stat_tag
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    property p_coarse_load; t0_pulse |=> stat_coarse == $past(coarse_off); endproperty
    property p_tag_load; t0_pulse |=> stat_tag == $past(tag_off); endproperty
    property p_coarse_count;
        !t0_pulse && stat_coarse < rollover |=> stat_coarse == $past(stat_coarse) + CNT_ONE;
    endproperty
    property p_tag_count;
        !t0_pulse && stat_tag < rollover |=> stat_tag == $past(stat_tag) + CNT_ONE;
    endproperty
    property p_coarse_wrap; !t0_pulse && stat_coarse == rollover |=> stat_coarse == CNT_ZERO;
    endproperty
    property p_tag_wrap; !t0_pulse && stat_tag == rollover |=> stat_tag == CNT_ZERO; endproperty
    property p_dist_kept;
        !t0_pulse && rollover == CNT_NATURAL_MAX |=> $stable(stat_coarse - stat_tag);
    endproperty
    property p_dist_load;
        t0_pulse |=> (stat_coarse - stat_tag) == $past(coarse_off - tag_off);
    endproperty
    property p_t0_wins;
        t0_pulse && coarse_off != stat_coarse + CNT_ONE
            |=> stat_coarse != $past(stat_coarse) + CNT_ONE;
    endproperty

    a_coarse_load: assert property (p_coarse_load) else $error("coarse start not loaded");
    a_tag_load: assert property (p_tag_load) else $error("tag start not loaded");
    a_coarse_count: assert property (p_coarse_count) else $error("coarse not counting");
    a_tag_count: assert property (p_tag_count) else $error("tag not counting");
    a_coarse_wrap: assert property (p_coarse_wrap) else $error("coarse wrap wrong");
    a_tag_wrap: assert property (p_tag_wrap) else $error("tag wrap wrong");
    a_dist_kept: assert property (p_dist_kept) else $error("latency distance drifted");
    a_dist_load: assert property (p_dist_load) else $error("latency distance wrong");
    a_t0_wins: assert property (p_t0_wins) else $error("count beat start load");

    c_t0: cover property (t0_pulse);
    c_wrap: cover property (stat_tag == rollover && rollover != CNT_NATURAL_MAX);
    c_trig: cover property (trig_pulse);
endmodule : tac_properties

// *** verification/tdc_time_alignment_counters_tb_top.sv ***
`timescale 1ns/100ps
module tdc_time_alignment_counters_tb_top;
    import tac_pkg::*;
    logic                    clk_sys = 1'b0;
    logic                    rst_b = 1'b0;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [7:0]              paddr = 8'h00;
    logic [31:0]             pwdata = 32'h0000_0000;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    hit = 1'b0;
    logic [TAP_W-1:0]        hit_tap = 5'h00;
    logic [1:0]              hit_chan = 2'h0;
    logic                    trig_valid;
    logic [CNT_W-1:0]        trig_tag;
    logic                    meas_valid;
    logic [TIME_W-1:0]       meas_time;
    logic                    meas_reject;
    logic [TIME_W-1:0]       reject_time;
    logic [TAP_N*TRIM_W-1:0] tap_load;
    logic [TAP_N*TAP_W-1:0]  tap_bin;
    logic [31:0]             rd;
    logic                    slverr;
    int                      fails = 0;
    int                      check_count = 0;

    always #5 clk_sys = ~clk_sys;

    tac_if u_tac_if ();
    tac_cfg u_tac_cfg (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(u_tac_if), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));
    tac_dev u_tac_dev (.CLK_SYS(clk_sys), .RST_B(rst_b), .LINK(u_tac_if), .HIT(hit),
        .HIT_TAP(hit_tap), .HIT_CHAN(hit_chan), .TRIG_VALID(trig_valid), .TRIG_TAG(trig_tag),
        .MEAS_VALID(meas_valid), .MEAS_TIME(meas_time), .MEAS_REJECT(meas_reject),
        .REJECT_TIME(reject_time), .TAP_LOAD(tap_load), .TAP_BIN(tap_bin));
    tac_properties u_tac_properties (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .t0_pulse(u_tac_if.t0_pulse), .trig_pulse(u_tac_if.trig_pulse),
        .coarse_off(u_tac_if.coarse_off), .tag_off(u_tac_if.tag_off),
        .rollover(u_tac_if.rollover), .stat_coarse(u_tac_if.stat_coarse),
        .stat_tag(u_tac_if.stat_tag));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [11:0] exp_off(input logic [11:0] c, input logic [11:0] l,
                                            input logic [11:0] r);
        return (c >= l) ? c - l : c - l + r + 12'h001;
    endfunction : exp_off

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic test_reset_values;
        apb(1'b0, OFS_LATENCY, 32'h0000_0000);
        check("latency", rd, 32'h0000_0100);
        apb(1'b0, OFS_ROLLOVER, 32'h0000_0000);
        check("rollover", rd, 32'h0000_0FFF);
        apb(1'b0, OFS_OFFSETS, 32'h0000_0000);
        check("offsets", rd, 32'h0EFD_0F00);
        apb(1'b1, 8'h24, 32'h0000_0001);
        check("unmapped", {31'h0, slverr}, 32'h0000_0001);
        $display("test_reset_values done");
    endtask : test_reset_values

    task automatic test_offsets;
        logic [11:0] cs [4] = '{12'h000, 12'h000, 12'h005, 12'h080};
        logic [11:0] ls [4] = '{12'h100, 12'h010, 12'h010, 12'h010};
        logic [11:0] rs [4] = '{12'hFFF, 12'h0FF, 12'h0FF, 12'h0FF};
        logic [11:0] tg;
        logic [11:0] rj;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_COARSE, {20'h0_0000, cs[i]});
            apb(1'b1, OFS_LATENCY, {20'h0_0000, ls[i]});
            apb(1'b1, OFS_ROLLOVER, {20'h0_0000, rs[i]});
            tg = exp_off(cs[i], ls[i], rs[i]);
            apb(1'b0, OFS_OFFSETS, 32'h0000_0000);
            rj = exp_off(cs[i], ls[i] + 12'h003, rs[i]);
            check("offsets", rd, {4'h0, rj, 4'h0, tg});
            apb(1'b1, OFS_CTRL, 32'h0000_0001);
            @(posedge clk_sys);
            #1;
            check("coarse load", 32'(u_tac_if.stat_coarse), 32'(cs[i]));
            check("tag load", 32'(u_tac_if.stat_tag), 32'(tg));
            repeat (ls[i]) @(posedge clk_sys);
            #1;
            check("tag at latency", 32'(u_tac_if.stat_tag), 32'(cs[i]));
        end
        $display("test_offsets done");
    endtask : test_offsets

    task automatic test_match;
        logic [11:0] ch;
        apb(1'b1, OFS_COARSE, 32'h0000_0000);
        apb(1'b1, OFS_LATENCY, 32'h0000_0020);
        apb(1'b1, OFS_ROLLOVER, 32'h0000_0FFF);
        apb(1'b1, OFS_CHAN_ADJ, 32'h0000_0300);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        @(posedge clk_sys);
        hit <= 1'b1;
        hit_tap <= 5'h10;
        hit_chan <= 2'h1;
        repeat (2) @(posedge clk_sys);
        #1;
        ch = u_tac_if.stat_coarse;
        while (u_tac_if.stat_tag !== ch - 12'h003) begin
            @(posedge clk_sys);
            #1;
        end
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        @(posedge clk_sys);
        #1;
        check("trig valid", {31'h0, trig_valid}, 32'h0000_0001);
        check("trig tag", {20'h0_0000, trig_tag}, {20'h0_0000, ch});
        check("meas valid", {31'h0, meas_valid}, 32'h0000_0001);
        check("meas time", {15'h0, meas_time}, {15'h0, ch, 5'h0E});
        @(posedge clk_sys);
        hit <= 1'b0;
        $display("test_match done");
    endtask : test_match

    task automatic test_reject;
        logic [11:0] ch;
        int          n;
        repeat (8) @(posedge clk_sys);
        hit <= 1'b1;
        hit_tap <= 5'h05;
        hit_chan <= 2'h0;
        repeat (2) @(posedge clk_sys);
        #1;
        ch = u_tac_if.stat_coarse;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (meas_reject !== 1'b1);
        check("reject age", {31'h0, n > 32 && n < 40}, 32'h0000_0001);
        check("reject time", {15'h0, reject_time}, {15'h0, ch - 12'h001, 5'h00});
        hit <= 1'b0;
        $display("test_reject done");
    endtask : test_reject

    task automatic test_trim;
        apb(1'b1, OFS_TRIM, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        #1;
        for (int k = 0; k < TAP_N; k++) begin
            check("tap load", {29'h0, tap_load[k*TRIM_W +: TRIM_W]}, k / 4);
            check("tap bin", {27'h0, tap_bin[k*TAP_W +: TAP_W]}, (k + 27) % 32);
        end
        apb(1'b1, OFS_TRIM, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        #1;
        check("trim zero", {31'h0, |tap_load}, 32'h0000_0000);
        $display("test_trim done");
    endtask : test_trim

    initial begin
        #200000;
        fails++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_reset_values();
        test_offsets();
        test_match();
        test_reject();
        test_trim();
        stop_test();
    end
endmodule : tdc_time_alignment_counters_tb_top
